// >>> logic/gpc_gpio_top.sv
// Three-port general purpose pin block with its special function registers
`timescale 1ns/1ps
module gpc_gpio_top (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    output logic O_SFR_HIT,
    input wire logic [23:0] I_PAD_IN,
    output logic [23:0] O_PAD_OUT,
    output logic [23:0] O_PAD_OUTPUT_ENABLE_N,
    output logic [23:0] O_PAD_PULL_ENABLE,
    output logic [23:0] O_PAD_PULL_SELECT,
    output logic [23:0] O_PAD_DRIVE_STRENGTH,
    output logic [23:0] O_CORE_IN,
    input wire logic I_CLOCK_OUT_ON,
    input wire logic I_CLOCK_OUT,
    input wire logic I_POWER_DOWN,
    input wire logic [23:0] I_WAKE_MASK,
    output logic [23:0] O_PIN_EVENT,
    output logic [1:0] O_EXT_INT,
    output logic O_WAKE,
    output logic [7:0] O_IRQ_VECTOR
);

    // ****************************************
    // Declarations
    // ****************************************
    gpc_pkg::gpc_port_cfg_t cfg_ff [gpc_pkg::NUM_PORTS];
    gpc_pkg::gpc_port_cfg_t nxt_cfg [gpc_pkg::NUM_PORTS];
    gpc_pkg::gpc_pad_ctl_t pad_ctl [gpc_pkg::NUM_PORTS];
    logic [2:0][7:0] core_in;
    logic [2:0][7:0] rd_part;
    logic [2:0] hit_part;
    logic [7:0] rd_value;
    logic rd_hit;
    logic [7:0] rdata_ff;
    logic hit_ff;
    logic clk_sync1_ff;
    logic clk_sync2_ff;
    logic [23:0] core_flat;
    logic [23:0] prev_ff;
    logic [23:0] change;
    logic [23:0] event_mask_flat;
    logic [23:0] event_ff;
    logic [23:0] nxt_event;
    logic wake_ff;
    logic nxt_wake;
    logic [1:0] ext_ff;
    logic [7:0] vector_ff;
    logic [7:0] nxt_vector;
    logic [3:0] prime_ff;
    logic armed;

    // ****************************************
    // Selected clock sampled into core domain
    // ****************************************
    // Two flops before the clock level reaches the pad mux
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            clk_sync1_ff <= 1'b0;
            clk_sync2_ff <= 1'b0;
        end else begin
            clk_sync1_ff <= I_CLOCK_OUT;
            clk_sync2_ff <= clk_sync1_ff;
        end
    end

    // ****************************************
    // Per-port registers and pads
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < gpc_pkg::NUM_PORTS; p++) begin : g_port
            localparam logic [7:0] VALID = gpc_pkg::VALID_MASK[p];
            wire logic hit_data;
            wire logic hit_dir;
            wire logic hit_gate;
            wire logic hit_drive;
            wire logic hit_pen;
            wire logic hit_psel;
            wire logic [7:0] wmask;
            wire logic [7:0] force_drive;
            wire logic [7:0] force_value;

            // Address decode for this port
            assign hit_data = I_SFR_ADDR == gpc_pkg::ADDR_DATA[p];
            assign hit_dir = I_SFR_ADDR == gpc_pkg::ADDR_DIR[p];
            assign hit_gate = I_SFR_ADDR == gpc_pkg::ADDR_GATE[p];
            assign hit_drive = I_SFR_ADDR == gpc_pkg::ADDR_DRIVE[p];
            assign hit_pen = I_SFR_ADDR == gpc_pkg::ADDR_PULL_EN[p];
            assign hit_psel = I_SFR_ADDR == gpc_pkg::ADDR_PULL_SEL[p];
            assign hit_part[p] = hit_data | hit_dir | hit_gate | hit_drive | hit_pen | hit_psel;

            // Reserved positions write as one in dir and gate, as zero in the other registers
            assign wmask = VALID;

            // Next register values on a write strobe
            assign nxt_cfg[p].data = (I_SFR_WR && hit_data) ?
                (I_SFR_WDATA & wmask) : cfg_ff[p].data;
            assign nxt_cfg[p].dir = (I_SFR_WR && hit_dir) ?
                ((I_SFR_WDATA & wmask) | ~wmask) : cfg_ff[p].dir;
            assign nxt_cfg[p].gate = (I_SFR_WR && hit_gate) ?
                ((I_SFR_WDATA & wmask) | ~wmask) : cfg_ff[p].gate;
            assign nxt_cfg[p].drive = (I_SFR_WR && hit_drive) ?
                (I_SFR_WDATA & wmask) : cfg_ff[p].drive;
            assign nxt_cfg[p].pull_en = (I_SFR_WR && hit_pen) ?
                (I_SFR_WDATA & wmask) : cfg_ff[p].pull_en;
            assign nxt_cfg[p].pull_sel = (I_SFR_WR && hit_psel) ?
                (I_SFR_WDATA & wmask) : cfg_ff[p].pull_sel;

            // Register file, input with pull-up after reset
            always_ff @(posedge I_CLK) begin
                if (!I_RESET_N) begin
                    cfg_ff[p].data <= gpc_pkg::RST_DATA;
                    cfg_ff[p].dir <= gpc_pkg::RST_DIR;
                    cfg_ff[p].gate <= gpc_pkg::RST_GATE;
                    cfg_ff[p].drive <= gpc_pkg::RST_DRIVE;
                    cfg_ff[p].pull_en <= gpc_pkg::RST_PULL_EN;
                    cfg_ff[p].pull_sel <= gpc_pkg::RST_PULL_SEL;
                end else begin
                    cfg_ff[p] <= nxt_cfg[p];
                end
            end

            // Readback; data returns the live pin state
            assign rd_part[p] =
                ({8{hit_data}} & core_in[p]) |
                ({8{hit_dir}} & cfg_ff[p].dir & VALID) |
                ({8{hit_gate}} & cfg_ff[p].gate & VALID) |
                ({8{hit_drive}} & cfg_ff[p].drive) |
                ({8{hit_pen}} & cfg_ff[p].pull_en) |
                ({8{hit_psel}} & cfg_ff[p].pull_sel);

            // Clock output takes over one pad of port 1
            if (p == gpc_pkg::CLK_OUT_PORT) begin : g_clk_out
                assign force_drive = {4'h0, I_CLOCK_OUT_ON, 3'h0};
                assign force_value = {4'h0, clk_sync2_ff, 3'h0};
            end else begin : g_no_clk_out
                assign force_drive = 8'h00;
                assign force_value = 8'h00;
            end

            gpc_pad_port #(
                .VALID(VALID)
            ) u_pad (
                .i_clk(I_CLK),
                .i_reset_n(I_RESET_N),
                .i_cfg(cfg_ff[p]),
                .i_force_drive(force_drive),
                .i_force_value(force_value),
                .i_pad_in(I_PAD_IN[p*8 +: 8]),
                .o_pad(pad_ctl[p]),
                .o_core_in(core_in[p])
            );

            // Flatten pad controls onto the pin buses
            assign O_PAD_OUT[p*8 +: 8] = pad_ctl[p].out;
            assign O_PAD_OUTPUT_ENABLE_N[p*8 +: 8] = pad_ctl[p].output_enable_n;
            assign O_PAD_PULL_ENABLE[p*8 +: 8] = pad_ctl[p].pull_enable;
            assign O_PAD_PULL_SELECT[p*8 +: 8] = pad_ctl[p].pull_select;
            assign O_PAD_DRIVE_STRENGTH[p*8 +: 8] = pad_ctl[p].drive_strength;
            assign core_flat[p*8 +: 8] = core_in[p];
            assign event_mask_flat[p*8 +: 8] = gpc_pkg::EVENT_MASK[p];
        end
    endgenerate

    // ****************************************
    // Register read port
    // ****************************************
    // Unmapped addresses read zero and report no hit
    assign rd_value = rd_part[0] | rd_part[1] | rd_part[2];
    assign rd_hit = |hit_part;

    // Read data registered one cycle after the strobe
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            rdata_ff <= gpc_pkg::RST_RDATA;
            hit_ff <= 1'b0;
        end else if (I_SFR_RD) begin
            rdata_ff <= rd_value;
            hit_ff <= rd_hit;
        end
    end

    assign O_SFR_RDATA = rdata_ff;
    assign O_SFR_HIT = hit_ff;
    assign O_CORE_IN = core_flat;

    // ****************************************
    // Pin events, external interrupts, wake-up
    // ****************************************
    // Any change of a gated input is an event candidate
    // No change is trusted until the input pipeline refilled after reset
    assign armed = prime_ff[3];
    assign change = core_flat ^ prev_ff;
    assign nxt_event = (I_POWER_DOWN || !armed) ? 24'h00_0000 : (change & event_mask_flat);
    assign nxt_wake = I_POWER_DOWN &&
        (|(change & I_WAKE_MASK & event_mask_flat & {24{armed}}) ||
         |core_flat[gpc_pkg::EXT_INT_HI:gpc_pkg::EXT_INT_LO]);
    assign nxt_vector = I_POWER_DOWN ? gpc_pkg::VEC_POWER_DOWN : gpc_pkg::VEC_NORMAL;

    // Event, wake and vector flops
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            prev_ff <= 24'h00_0000;
            event_ff <= 24'h00_0000;
            wake_ff <= 1'b0;
            ext_ff <= 2'h0;
            vector_ff <= gpc_pkg::VEC_NORMAL;
            prime_ff <= 4'h0;
        end else begin
            prime_ff <= {prime_ff[2:0], 1'b1};
            prev_ff <= core_flat;
            event_ff <= nxt_event;
            wake_ff <= nxt_wake;
            ext_ff <= core_flat[gpc_pkg::EXT_INT_HI:gpc_pkg::EXT_INT_LO];
            vector_ff <= nxt_vector;
        end
    end

    assign O_PIN_EVENT = event_ff;
    assign O_EXT_INT = ext_ff;
    assign O_WAKE = wake_ff;
    assign O_IRQ_VECTOR = vector_ff;

endmodule : gpc_gpio_top

// >>> logic/gpc_pkg.sv
// Constants, register map and carrier types for the port pad control block
// Overview of operation
// - Twenty-two pins sit on ports 0, 1 and 3, with port 1 bits 2 and 5 left reserved.
// - A pad drives its output value when output enable is low, else floats or pulls per pull bits.
// - After reset every pin is an input with its pull-up switched on.
// - Reading a data register returns the live pin state; data contents reset to zero.
// - Writing a data register sets the output value of every non-reserved bit of that port.
// - A direction bit of 1 makes the pin an input and 0 an output, all bits resetting to one.
// - An input-gating bit of 1 passes the pad into the core and 0 blocks it, all resetting to one.
// - Every pin except port 3 bits 3 and 2 raises a pin event, only in normal mode.
// - Port 3 bits 3 and 2 act as external interrupt inputs that wake the part from power-down.
// - General pins may act as wake-up sources while powered down.
// - With the clock output on, the selected clock drives port 1 bit 3; it is off after reset.
// - Each pin has its own direction, pull-up or pull-down, drive strength and input disable.
// - The pin interrupt vector is 0x83 in normal mode and 0x7B in power-down mode.
package gpc_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int NUM_PORTS = 3;
    localparam int PORT_BITS = 8;
    localparam int NUM_PINS = NUM_PORTS * PORT_BITS;

    // ****************************************
    // Register offsets, index 0/1/2 = port 0/1/3
    // ****************************************
    localparam logic [2:0][7:0] ADDR_DATA = {8'hB0, 8'h90, 8'h80};
    localparam logic [2:0][7:0] ADDR_DIR = {8'hB4, 8'hB2, 8'hB1};
    localparam logic [2:0][7:0] ADDR_GATE = {8'hBC, 8'hBA, 8'hB9};
    localparam logic [2:0][7:0] ADDR_DRIVE = {8'hC4, 8'hC2, 8'hC1};
    localparam logic [2:0][7:0] ADDR_PULL_EN = {8'hAC, 8'hAA, 8'hA9};
    localparam logic [2:0][7:0] ADDR_PULL_SEL = {8'hA4, 8'hA2, 8'hA1};

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_GATE = 8'hFF;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_PULL_EN = 8'hFF;
    localparam logic [7:0] RST_PULL_SEL = 8'hFF;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [2:0][7:0] VALID_MASK = {8'hFF, 8'hDB, 8'hFF};
    localparam logic [2:0][7:0] EVENT_MASK = {8'hF3, 8'hDB, 8'hFF};
    localparam int CLK_OUT_PORT = 1;
    localparam int CLK_OUT_BIT = 3;
    localparam int EXT_INT_LO = 18;
    localparam int EXT_INT_HI = 19;
    localparam logic [7:0] VEC_NORMAL = 8'h83;
    localparam logic [7:0] VEC_POWER_DOWN = 8'h7B;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] gate;
        logic [7:0] drive;
        logic [7:0] pull_en;
        logic [7:0] pull_sel;
    } gpc_port_cfg_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] output_enable_n;
        logic [7:0] pull_enable;
        logic [7:0] pull_select;
        logic [7:0] drive_strength;
    } gpc_pad_ctl_t;

endpackage : gpc_pkg

// >>> logic/gpc_pad_port.sv
// Pad control and input path for one 8-bit port
`timescale 1ns/1ps
module gpc_pad_port #(
    parameter logic [7:0] VALID = 8'hFF
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input gpc_pkg::gpc_port_cfg_t i_cfg,
    input wire logic [7:0] i_force_drive,
    input wire logic [7:0] i_force_value,
    input wire logic [7:0] i_pad_in,
    output gpc_pkg::gpc_pad_ctl_t o_pad,
    output logic [7:0] o_core_in
);

    // ****************************************
    // Pad control
    // ****************************************
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] core_ff;
    gpc_pkg::gpc_pad_ctl_t pad_ff;
    gpc_pkg::gpc_pad_ctl_t nxt_pad;
    logic [7:0] nxt_core;

    // Reserved bits float with no pull, forced bits always drive
    assign nxt_pad.out = ((i_cfg.data & ~i_force_drive) | (i_force_value & i_force_drive)) & VALID;
    assign nxt_pad.output_enable_n = (i_cfg.dir & ~i_force_drive) | ~VALID;
    assign nxt_pad.pull_enable = i_cfg.pull_en & VALID;
    assign nxt_pad.pull_select = i_cfg.pull_sel & VALID;
    assign nxt_pad.drive_strength = i_cfg.drive & VALID;
    // Gated or reserved inputs read as zero
    assign nxt_core = sync2_ff & i_cfg.gate & VALID;

    // Registered pad drive, input with pull-up in reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pad_ff.out <= gpc_pkg::RST_DATA;
            pad_ff.output_enable_n <= gpc_pkg::RST_DIR;
            pad_ff.pull_enable <= gpc_pkg::RST_PULL_EN & VALID;
            pad_ff.pull_select <= gpc_pkg::RST_PULL_SEL & VALID;
            pad_ff.drive_strength <= gpc_pkg::RST_DRIVE;
        end else begin
            pad_ff <= nxt_pad;
        end
    end

    // Two-stage pin synchroniser, then gated sample
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync1_ff <= gpc_pkg::RST_DATA;
            sync2_ff <= gpc_pkg::RST_DATA;
            core_ff <= gpc_pkg::RST_DATA;
        end else begin
            sync1_ff <= i_pad_in;
            sync2_ff <= sync1_ff;
            core_ff <= nxt_core;
        end
    end

    assign o_pad = pad_ff;
    assign o_core_in = core_ff;

endmodule : gpc_pad_port

// >>> dv/gpc_gpio_chk.sv
// Boundary checks for the port pad control block
`timescale 1ns/1ps
module gpc_gpio_chk (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic O_SFR_HIT,
    input wire logic [23:0] O_PAD_OUT,
    input wire logic [23:0] O_PAD_OUTPUT_ENABLE_N,
    input wire logic [23:0] O_CORE_IN,
    input wire logic I_CLOCK_OUT_ON,
    input wire logic I_POWER_DOWN,
    input wire logic [23:0] O_PIN_EVENT,
    input wire logic [1:0] O_EXT_INT,
    input wire logic O_WAKE,
    input wire logic [7:0] O_IRQ_VECTOR
);
    // ********
    // Sequences and properties
    // ********
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Lone write to one address, not repeated next cycle
    sequence s_wr1(logic [7:0] a);
        (I_SFR_WR && I_SFR_ADDR == a) ##1 !(I_SFR_WR && I_SFR_ADDR == a);
    endsequence
    property p_rd_hit; I_SFR_RD && I_SFR_ADDR == 8'h80 |=> O_SFR_HIT; endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("data read missed");
    property p_rd_unmap; I_SFR_RD && I_SFR_ADDR == 8'h00 |=> !O_SFR_HIT && O_SFR_RDATA == 8'h00; endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read answered");
    property p_rd_hold; !I_SFR_RD |=> $stable(O_SFR_RDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_dir; s_wr1(8'hB1) |-> ##2 O_PAD_OUTPUT_ENABLE_N[7:0] == $past(I_SFR_WDATA, 3); endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");
    property p_data; s_wr1(8'h80) |-> ##2 O_PAD_OUT[7:0] == $past(I_SFR_WDATA, 3); endproperty
    a_data: assert property (p_data) else $error("output value not applied");
    property p_resv; O_PAD_OUTPUT_ENABLE_N[13] && O_PAD_OUTPUT_ENABLE_N[10]
        && (O_PAD_OUT[13] | O_PAD_OUT[10] | O_CORE_IN[13] | O_CORE_IN[10]) == 1'b0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit active");
    property p_ev_pd; I_POWER_DOWN [*2] |-> O_PIN_EVENT == 24'h00_0000; endproperty
    a_ev_pd: assert property (p_ev_pd) else $error("event while powered down");
    property p_ev_cause; O_PIN_EVENT[16] |-> $past(O_CORE_IN[16]) != $past(O_CORE_IN[16], 2); endproperty
    a_ev_cause: assert property (p_ev_cause) else $error("event without change");
    property p_ev_ext; O_PIN_EVENT[19:18] == 2'b00; endproperty
    a_ev_ext: assert property (p_ev_ext) else $error("event on external line");
    property p_vec; 1'b1 |=> O_IRQ_VECTOR == ($past(I_POWER_DOWN) ? 8'h7B : 8'h83); endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_wake; I_POWER_DOWN [*2] ##0 (O_EXT_INT & O_CORE_IN[19:18]) != 2'b00 |=> O_WAKE; endproperty
    a_wake: assert property (p_wake) else $error("no wake from external line");
    property p_clk_out; I_CLOCK_OUT_ON [*5] |-> !O_PAD_OUTPUT_ENABLE_N[11]; endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock pin not driven");
endmodule : gpc_gpio_chk

bind gpc_gpio_top gpc_gpio_chk u_chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA),
    .O_SFR_RDATA(O_SFR_RDATA), .O_SFR_HIT(O_SFR_HIT), .O_PAD_OUT(O_PAD_OUT),
    .O_PAD_OUTPUT_ENABLE_N(O_PAD_OUTPUT_ENABLE_N), .O_CORE_IN(O_CORE_IN),
    .I_CLOCK_OUT_ON(I_CLOCK_OUT_ON), .I_POWER_DOWN(I_POWER_DOWN), .O_PIN_EVENT(O_PIN_EVENT),
    .O_EXT_INT(O_EXT_INT), .O_WAKE(O_WAKE), .O_IRQ_VECTOR(O_IRQ_VECTOR));

// >>> dv/gpc_pads_model.sv
// Board-side pad model resolving each pin level
`timescale 1ns/1ps
module gpc_pads_model (
    input wire logic i_clk,
    input wire logic [23:0] i_out,
    input wire logic [23:0] i_oe_n,
    input wire logic [23:0] i_pull_en,
    input wire logic [23:0] i_pull_sel,
    input wire logic [23:0] i_ext_en,
    input wire logic [23:0] i_ext_val,
    output logic [23:0] o_pad
);
    logic [23:0] float_ff = 24'h00_0000;
    // Floating pins wander every cycle
    always @(posedge i_clk) begin
        float_ff <= ~float_ff;
    end
    // Device drive first, then board, then pull
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (!i_oe_n[i]) o_pad[i] = i_out[i];
            else if (i_ext_en[i]) o_pad[i] = i_ext_val[i];
            else if (i_pull_en[i]) o_pad[i] = i_pull_sel[i];
            else o_pad[i] = float_ff[i];
        end
    end
endmodule : gpc_pads_model

// >>> dv/testbench.sv
// Self-checking bench for the port pad control block
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e; logic h;} gpc_row_t;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, clk_on = 1'b0, clk_src = 1'b0, pd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, vector;
    logic [23:0] wake_mask = 24'h00_0000, ext_en = 24'h00_0000, ext_val = 24'h00_0000;
    logic [23:0] pad_in, pad_out, oe_n, pull_en, pull_sel, drive, core_in, pin_event;
    logic hit, wake;
    logic [1:0] ext_int;
    int miscompares = 0, compares = 0, cycles = 0, ev_cnt = 0, wk_cnt = 0;
    gpc_row_t rows [7] = '{'{8'hB1, 8'hFE, 8'hFE, 1'b1}, '{8'hB2, 8'hFF, 8'hDB, 1'b1},
        '{8'hC2, 8'hFF, 8'hDB, 1'b1},
        '{8'hB4, 8'h5A, 8'h5A, 1'b1}, '{8'hBA, 8'h00, 8'h00, 1'b1},
        '{8'hBC, 8'h3C, 8'h3C, 1'b1}, '{8'h00, 8'hAA, 8'h00, 1'b0}};
    // ********
    // Design, pads and clocks
    // ********
    gpc_gpio_top dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
        .I_SFR_RD(rd), .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .O_SFR_HIT(hit),
        .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OUTPUT_ENABLE_N(oe_n),
        .O_PAD_PULL_ENABLE(pull_en), .O_PAD_PULL_SELECT(pull_sel), .O_PAD_DRIVE_STRENGTH(drive),
        .O_CORE_IN(core_in), .I_CLOCK_OUT_ON(clk_on), .I_CLOCK_OUT(clk_src), .I_POWER_DOWN(pd),
        .I_WAKE_MASK(wake_mask), .O_PIN_EVENT(pin_event), .O_EXT_INT(ext_int), .O_WAKE(wake),
        .O_IRQ_VECTOR(vector));
    gpc_pads_model pads (.i_clk(clk), .i_out(pad_out), .i_oe_n(oe_n), .i_pull_en(pull_en),
        .i_pull_sel(pull_sel), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad_in));
    always #20 clk = ~clk;
    // Clock source, event and wake counts, hang limit
    always @(posedge clk) begin
        clk_src <= ~clk_src;
        cycles++;
        if (pin_event[16] === 1'b1) ev_cnt++;
        if (wake === 1'b1) wk_cnt++;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ********
    // Tasks
    // ********
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk("rdata", {16'h0000, rdata}, {16'h0000, e});
        chk("hit", {23'h00_0000, hit}, {23'h00_0000, h});
    endtask : rd_chk
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        chk("oe_n", oe_n, 24'hFF_FFFF);
        chk("pull_en", pull_en, 24'hFF_DBFF);
        chk("pull_sel", pull_sel, 24'hFF_DBFF);
        chk("drive", drive, 24'h00_0000);
        chk("core", core_in, 24'hFF_DBFF);
        chk("vec", {16'h0000, vector}, 24'h00_0083);
        rd_chk(8'hB1, 8'hFF, 1'b1);
        rd_chk(8'hBC, 8'hFF, 1'b1);
    endtask : do_reset
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // ********
    // Main sequence
    // ********
    initial begin
        do_reset();
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].e, rows[i].h);
        end
        // Port 0 driven and looped back, then gated
        wr_reg(8'hB9, 8'hFF);
        wr_reg(8'hB1, 8'h00);
        wr_reg(8'h80, 8'hA5);
        settle();
        chk("out0", {16'h0000, pad_out[7:0]}, 24'h00_00A5);
        chk("oe_n0", {16'h0000, oe_n[7:0]}, 24'h00_0000);
        rd_chk(8'h80, 8'hA5, 1'b1);
        wr_reg(8'hB9, 8'h0F);
        settle();
        chk("core0", {16'h0000, core_in[7:0]}, 24'h00_0005);
        rd_chk(8'h80, 8'h05, 1'b1);
        // Port 1 reserved bits under full write
        wr_reg(8'hB2, 8'h00);
        wr_reg(8'h90, 8'hFF);
        settle();
        chk("out1", {16'h0000, pad_out[15:8]}, 24'h00_00DB);
        chk("oe_n1", {16'h0000, oe_n[15:8]}, 24'h00_0024);
        chk("drv1", {16'h0000, drive[15:8]}, 24'h00_00DB);
        // Port 3 pulled down, then pull removed
        wr_reg(8'hB4, 8'hFF);
        wr_reg(8'hBC, 8'hFF);
        wr_reg(8'hA4, 8'h00);
        settle();
        chk("sel3", {16'h0000, pull_sel[23:16]}, 24'h00_0000);
        chk("core3", {16'h0000, core_in[23:16]}, 24'h00_0000);
        wr_reg(8'hAC, 8'h00);
        settle();
        chk("pe3", {16'h0000, pull_en[23:16]}, 24'h00_0000);
        // Board drives port 3: events, then power-down wake
        ext_en <= 24'hFF_0000;
        settle();
        ev_cnt = 0;
        ext_val[16] <= 1'b1;
        ext_val[18] <= 1'b1;
        settle();
        chk("events", ev_cnt[23:0], 24'h00_0001);
        pd <= 1'b1;
        wake_mask <= 24'h01_0000;
        ext_val[18] <= 1'b0;
        settle();
        chk("vec_pd", {16'h0000, vector}, 24'h00_007B);
        ev_cnt = 0;
        wk_cnt = 0;
        ext_val[16] <= 1'b0;
        settle();
        chk("events_pd", ev_cnt[23:0], 24'h00_0000);
        chk("wake_pin", {23'h00_0000, wk_cnt != 0}, 24'h00_0001);
        ext_val[18] <= 1'b1;
        settle();
        chk("ext_int", {22'h00_0000, ext_int}, 24'h00_0001);
        chk("wake_ext", {23'h00_0000, wake}, 24'h00_0001);
        pd <= 1'b0;
        ext_en <= 24'h00_0000;
        // Clock output takes port 1 bit 3, then reset mid-run
        wr_reg(8'hB2, 8'hFF);
        clk_on <= 1'b1;
        settle();
        chk("oe_n_clk", {23'h00_0000, oe_n[11]}, 24'h00_0000);
        chk("clk_pin", {23'h00_0000, pad_out[11]}, {23'h00_0000, ~clk_src});
        clk_on <= 1'b0;
        do_reset();
        print_verdict();
    end
endmodule : testbench
